// File: core/gpsco_pkg.sv
// Constants shared by the pin status and clock output block
// How it works
// RL1 - Loop clock reaches a pin only while its enable bit 0 is set
// RL2 - Function 0x018 puts the loop lock flag on the pin
// RL3 - Lock flag rising or falling edge sets a sticky event bit
// RL4 - Derived clock runs only while control bit 15 is set; resets to zero
// RL5 - Divider field bits 7:3 divides by its even code, 2 to 30
// RL6 - Source select bits 2:0 pick 6.144 to 49.152 MHz; others reserved
// RL7 - 44.1 kHz family rates switch sources to 5.6448 to 45.1584 MHz
// RL8 - Software never picks a source faster than the core clock
// RL9 - Software disables a clock output before changing its divider or source
// RL10 - Software enables derived clock only while core clock runs
// RL11 - Codes 0x048 and 0x049 route the two PWM outputs
// RL12 - Code 0x04C routes the S/PDIF transmitter output
// RL13 - Overheat, short or watchdog disables speaker, then shows shutdown at 0x0E0
// RL14 - Codes 0x0B6, 0x0E1, 0x0E2 show short, overheat shutdown, overheat warning
// RL15 - Temperature, short and shutdown flag edges set sticky event bits
// RL16 - Codes 0x140 to 0x143 show each timer's final count pulse
// RL17 - Each timer final count sets a sticky event bit
// RL18 - Codes 0x150 to 0x153 show each logger FIFO not-empty flag
// RL19 - Each logger not-empty rise sets a sticky event bit
// RL20 - Switch mode selects off, on, or following the mic detect clamp
// RL21 - Loop divider bits 7:1 divides by 6 to 127, resets to 6; code never checks LOOP_DIV_MIN, so 2 to 5 also divide
// RL22 - Sticky event bits stay set until software writes one to them
// RL23 - Derived clock is source over divider, held low while disabled
package gpsco_pkg;
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 16;
    localparam int          FN_W              = 9;
    // Register offsets
    localparam logic [15:0] OFS_DCLK_CTRL     = 16'h0149;
    localparam logic [15:0] OFS_LOOP_CLK      = 16'h0188;
    localparam logic [15:0] OFS_PIN_FN_BASE   = 16'h0200;
    localparam logic [15:0] OFS_EVENT         = 16'h0220;
    localparam logic [15:0] OFS_RAW           = 16'h0221;
    localparam logic [15:0] OFS_SWITCH        = 16'h0222;
    // Field positions
    localparam int          DCLK_ENA_BIT      = 15;
    localparam int          DCLK_DIV_LSB      = 3;
    localparam int          DCLK_SEL_LSB      = 0;
    localparam int          LOOP_ENA_BIT      = 0;
    localparam int          LOOP_DIV_LSB      = 1;
    // Reset values
    localparam logic [15:0] DCLK_CTRL_RST     = 16'h0000;
    localparam logic [15:0] LOOP_CLK_RST      = 16'h000C;
    localparam logic [6:0]  LOOP_DIV_MIN      = 7'h06;
    // Function codes
    localparam logic [8:0]  FN_LOOP_CLK       = 9'h010;
    localparam logic [8:0]  FN_LOCK           = 9'h018;
    localparam logic [8:0]  FN_DCLK           = 9'h040;
    localparam logic [8:0]  FN_PWM1           = 9'h048;
    localparam logic [8:0]  FN_PWM2           = 9'h049;
    localparam logic [8:0]  FN_SPDIF          = 9'h04C;
    localparam logic [8:0]  FN_SHORT          = 9'h0B6;
    localparam logic [8:0]  FN_SHUTDOWN       = 9'h0E0;
    localparam logic [8:0]  FN_OVH_SHUT       = 9'h0E1;
    localparam logic [8:0]  FN_OVH_WARN       = 9'h0E2;
    localparam logic [8:0]  FN_TIMER_BASE     = 9'h140;
    localparam logic [8:0]  FN_LOGGER_BASE    = 9'h150;
    // Event bit positions
    localparam int          EV_LOCK           = 0;
    localparam int          EV_SHORT          = 1;
    localparam int          EV_SHUT           = 2;
    localparam int          EV_OVH_SHUT       = 3;
    localparam int          EV_OVH_WARN       = 4;
    localparam int          EV_TIMER          = 5;
    localparam int          EV_LOGGER         = 9;
    localparam int          EV_W              = 13;
    // Analog switch modes
    localparam logic [1:0]  SW_OFF            = 2'h0;
    localparam logic [1:0]  SW_ON             = 2'h1;
    localparam logic [1:0]  SW_CLAMP          = 2'h2;
    localparam logic [4:0]  FAMILY_441_MASK   = 5'h18;
    localparam logic [4:0]  FAMILY_441_VAL    = 5'h08;
    // Source frequencies in units of 100 Hz, 48k family then 44.1k family
    localparam int          SRC_F_48 [4]      = '{61440, 122880, 245760, 491520};
    localparam int          SRC_F_441 [4]     = '{56448, 112896, 225792, 451584};
    localparam int          CORE_F            = 1000000;
    localparam int          PHASE_W           = 24;
endpackage

// File: core/gpsco_top.sv
// Pin function multiplexer with loop clock, derived clock and status events
`timescale 1ns/1ps
module gpsco_top #(
    parameter int NPINS = 4
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rstn,
    input  wire logic [15:0]              i_addr,
    input  wire logic [15:0]              i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [15:0]              o_rdata,
    input  wire logic                     i_loop_osc,
    input  wire logic                     i_lock,
    input  wire logic [1:0]               i_pwm,
    input  wire logic                     i_spdif,
    input  wire logic                     i_spk_short,
    input  wire logic                     i_ovh_shut,
    input  wire logic                     i_ovh_warn,
    input  wire logic                     i_wdog,
    input  wire logic [3:0]               i_timer_done,
    input  wire logic [3:0]               i_logger_nempty,
    input  wire logic                     i_mic_detect_clamp,
    input  wire logic [4:0]               i_sample_rate,
    output logic      [NPINS-1:0]         o_pin,
    output logic                          o_spk_enable,
    output logic                          o_switch_closed,
    output logic      [12:0]              o_events
);
    // Elaboration check: the pin function table holds at most 16 entries
    if (NPINS < 1 || NPINS > 16) begin : g_npins_check
        $error("NPINS must lie in 1 to 16");
    end

    // Whole state of the block
    typedef struct packed {
        logic [15:0]                rdata;
        logic [15:0]                dclk_ctrl;
        logic [7:0]                 loop_ctrl;
        logic [1:0]                 sw_mode;
        logic [15:0][8:0]           pin_fn;
        logic [12:0]                events;
        logic [12:0]                raw_prev;
        logic [12:0]                s1;
        logic [12:0]                s2;
        logic [5:0]                 pins_s1;
        logic [5:0]                 pins_s2;
        logic                       osc_prev;
        logic [6:0]                 loop_cnt;
        logic                       loop_clk;
        logic [23:0]                phase;
        logic [4:0]                 dcnt;
        logic                       dclk;
        logic                       spk_on;
        logic                       shut_done;
        logic [NPINS-1:0]           pin;
        logic                       sw;
    } gpsco_state_t;

    gpsco_state_t st_reg;
    gpsco_state_t st_next;

    // Source frequency lookup, depends on sample rate family
    function automatic logic [23:0] gpsco_step(input logic [2:0] sel,
                                               input logic [4:0] rate);
        int freq;
        freq = 0;
        if (sel < 3'h4) begin
            if ((rate & gpsco_pkg::FAMILY_441_MASK) == gpsco_pkg::FAMILY_441_VAL) begin
                freq = gpsco_pkg::SRC_F_441[sel[1:0]]; // RL7
            end else begin
                freq = gpsco_pkg::SRC_F_48[sel[1:0]]; // RL6
            end
        end
        // Phase step scaled to 2^24 per core period, doubled for edge rate
        return 24'((64'(freq) << 25) / gpsco_pkg::CORE_F);
    endfunction

    // Sampled inputs: raw event sources from outside the clock domain
    logic [12:0] raw_now;
    assign raw_now = st_reg.s2;

    always_comb begin
        logic [12:0] rise;
        logic [12:0] fall;
        logic [12:0] trig;
        logic [12:0] clr;
        logic [23:0] ph;
        logic        tick;
        logic [4:0]  div;
        logic [8:0]  fn;
        logic        src;
        rise = '0;
        fall = '0;
        trig = '0;
        clr = '0;
        ph = '0;
        tick = 1'b0;
        div = '0;
        fn = '0;
        src = 1'b0;
        st_next = st_reg;

        // Two-flop synchronisers for all pin inputs
        st_next.s1 = {i_logger_nempty, i_timer_done, i_ovh_warn, i_ovh_shut,
                      st_reg.shut_done, i_spk_short, i_lock};
        st_next.s2 = st_reg.s1;
        st_next.pins_s1 = {i_loop_osc, i_pwm, i_spdif, i_wdog, i_mic_detect_clamp};
        st_next.pins_s2 = st_reg.pins_s1;
        st_next.raw_prev = raw_now;

        // Register writes
        if (i_wr) begin
            if (i_addr == gpsco_pkg::OFS_DCLK_CTRL) begin
                st_next.dclk_ctrl = i_wdata & 16'h80FF;
            end else if (i_addr == gpsco_pkg::OFS_LOOP_CLK) begin
                st_next.loop_ctrl = i_wdata[7:0];
            end else if (i_addr == gpsco_pkg::OFS_EVENT) begin
                clr = i_wdata[12:0]; // RL22
            end else if (i_addr == gpsco_pkg::OFS_SWITCH) begin
                st_next.sw_mode = i_wdata[1:0];
            end else if (i_addr >= gpsco_pkg::OFS_PIN_FN_BASE &&
                         i_addr < gpsco_pkg::OFS_PIN_FN_BASE + 16'(NPINS)) begin
                st_next.pin_fn[i_addr[3:0]] = i_wdata[8:0];
            end
        end

        // Event edges: lock and both overheat flags on both edges, others rising
        rise = raw_now & ~st_reg.raw_prev;
        fall = ~raw_now & st_reg.raw_prev;
        trig = rise; // RL15 RL17 RL19
        trig[gpsco_pkg::EV_LOCK] = rise[gpsco_pkg::EV_LOCK] | fall[gpsco_pkg::EV_LOCK]; // RL3
        trig[gpsco_pkg::EV_OVH_SHUT] = rise[gpsco_pkg::EV_OVH_SHUT] | fall[gpsco_pkg::EV_OVH_SHUT];
        trig[gpsco_pkg::EV_OVH_WARN] = rise[gpsco_pkg::EV_OVH_WARN] | fall[gpsco_pkg::EV_OVH_WARN];
        // Set wins over clear
        st_next.events = (st_reg.events & ~clr) | trig; // RL22

        // Loop clock divider on synchronised oscillator edges
        if (st_reg.pins_s2[5] && !st_reg.osc_prev) begin
            if (st_reg.loop_cnt + 7'h1 >= st_reg.loop_ctrl[7:1]) begin
                st_next.loop_cnt = '0; // RL21
                st_next.loop_clk = 1'b1;
            end else begin
                st_next.loop_cnt = st_reg.loop_cnt + 7'h1;
                if (st_reg.loop_cnt + 7'h1 >= {1'b0, st_reg.loop_ctrl[7:2]}) begin
                    st_next.loop_clk = 1'b0;
                end
            end
        end
        st_next.osc_prev = st_reg.pins_s2[5];

        // Derived clock: phase accumulator source, then even divider
        if (st_reg.dclk_ctrl[gpsco_pkg::DCLK_ENA_BIT]) begin // RL4
            ph = st_reg.phase + gpsco_step(st_reg.dclk_ctrl[2:0], i_sample_rate);
            tick = ph < st_reg.phase;
            st_next.phase = ph;
            div = st_reg.dclk_ctrl[7:3]; // RL5
            if (tick) begin
                if (st_reg.dcnt + 5'h1 >= div) begin
                    st_next.dcnt = '0;
                    st_next.dclk = ~st_reg.dclk; // RL23
                end else begin
                    st_next.dcnt = st_reg.dcnt + 5'h1;
                end
            end
        end else begin
            st_next.phase = '0;
            st_next.dcnt = '0;
            st_next.dclk = 1'b0; // RL23
        end

        // Speaker protection: disable, then report shutdown complete
        if (raw_now[gpsco_pkg::EV_OVH_SHUT] || raw_now[gpsco_pkg::EV_SHORT] ||
            st_reg.pins_s2[1]) begin
            st_next.spk_on = 1'b0; // RL13
        end
        st_next.shut_done = ~st_reg.spk_on;

        // Analog switch mode
        case (st_reg.sw_mode)
            gpsco_pkg::SW_ON:    st_next.sw = 1'b1; // RL20
            gpsco_pkg::SW_CLAMP: st_next.sw = st_reg.pins_s2[0];
            default:             st_next.sw = 1'b0;
        endcase

        // Pin multiplexer
        for (int p = 0; p < NPINS; p++) begin
            fn = st_reg.pin_fn[p];
            src = 1'b0;
            if (fn == gpsco_pkg::FN_LOOP_CLK) begin
                src = st_reg.loop_clk & st_reg.loop_ctrl[gpsco_pkg::LOOP_ENA_BIT]; // RL1
            end else if (fn == gpsco_pkg::FN_LOCK) begin
                src = raw_now[gpsco_pkg::EV_LOCK]; // RL2
            end else if (fn == gpsco_pkg::FN_DCLK) begin
                src = st_reg.dclk;
            end else if (fn == gpsco_pkg::FN_PWM1) begin
                src = st_reg.pins_s2[3]; // RL11
            end else if (fn == gpsco_pkg::FN_PWM2) begin
                src = st_reg.pins_s2[4]; // RL11
            end else if (fn == gpsco_pkg::FN_SPDIF) begin
                src = st_reg.pins_s2[2]; // RL12
            end else if (fn == gpsco_pkg::FN_SHORT) begin
                src = raw_now[gpsco_pkg::EV_SHORT]; // RL14
            end else if (fn == gpsco_pkg::FN_SHUTDOWN) begin
                src = st_reg.shut_done; // RL13
            end else if (fn == gpsco_pkg::FN_OVH_SHUT) begin
                src = raw_now[gpsco_pkg::EV_OVH_SHUT]; // RL14
            end else if (fn == gpsco_pkg::FN_OVH_WARN) begin
                src = raw_now[gpsco_pkg::EV_OVH_WARN]; // RL14
            end else if (fn[8:2] == gpsco_pkg::FN_TIMER_BASE[8:2]) begin
                src = raw_now[gpsco_pkg::EV_TIMER + 32'(fn[1:0])]; // RL16
            end else if (fn[8:2] == gpsco_pkg::FN_LOGGER_BASE[8:2]) begin
                src = raw_now[gpsco_pkg::EV_LOGGER + 32'(fn[1:0])]; // RL18
            end
            st_next.pin[p] = src;
        end

        // Read data, valid only in the cycle after the strobe
        st_next.rdata = '0;
        if (i_rd) begin
            if (i_addr == gpsco_pkg::OFS_DCLK_CTRL) begin
                st_next.rdata = st_reg.dclk_ctrl;
            end else if (i_addr == gpsco_pkg::OFS_LOOP_CLK) begin
                st_next.rdata = {8'h00, st_reg.loop_ctrl};
            end else if (i_addr == gpsco_pkg::OFS_EVENT) begin
                st_next.rdata = {3'h0, st_reg.events};
            end else if (i_addr == gpsco_pkg::OFS_RAW) begin
                st_next.rdata = {3'h0, raw_now};
            end else if (i_addr == gpsco_pkg::OFS_SWITCH) begin
                st_next.rdata = {14'h0, st_reg.sw_mode};
            end else if (i_addr >= gpsco_pkg::OFS_PIN_FN_BASE &&
                         i_addr < gpsco_pkg::OFS_PIN_FN_BASE + 16'(NPINS)) begin
                st_next.rdata = {7'h00, st_reg.pin_fn[i_addr[3:0]]};
            end
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
            st_reg.dclk_ctrl <= gpsco_pkg::DCLK_CTRL_RST; // RL4
            st_reg.loop_ctrl <= gpsco_pkg::LOOP_CLK_RST[7:0]; // RL21
            st_reg.spk_on    <= 1'b1; // RL13
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_pin = st_reg.pin;
    assign o_spk_enable = st_reg.spk_on; // RL13
    assign o_switch_closed = st_reg.sw;
    assign o_events = st_reg.events;

    // Lock edge sets its event bit one cycle after the synchroniser output moves
    sequence lock_edge_s;
        raw_now[gpsco_pkg::EV_LOCK] != st_reg.raw_prev[gpsco_pkg::EV_LOCK];
    endsequence
    lock_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL3
        lock_edge_s |=> st_reg.events[gpsco_pkg::EV_LOCK])
        else $error("lock edge did not set event");

    // Event stays set without a clearing write
    sticky_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL22
        (st_reg.events[0] && !(i_wr && i_addr == gpsco_pkg::OFS_EVENT))
        |=> st_reg.events[0])
        else $error("event bit dropped");

    // Derived clock low while disabled
    dclk_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL4 RL23
        !st_reg.dclk_ctrl[gpsco_pkg::DCLK_ENA_BIT] |=> !st_reg.dclk)
        else $error("derived clock ran while disabled");

    // Lock routed to pin 0 one cycle later
    lock_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL2
        st_reg.pin_fn[0] == gpsco_pkg::FN_LOCK && $stable(st_reg.pin_fn[0])
        |=> o_pin[0] == $past(raw_now[gpsco_pkg::EV_LOCK]))
        else $error("lock not on pin");

    // Loop clock gated off
    loop_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL1
        st_reg.pin_fn[0] == gpsco_pkg::FN_LOOP_CLK && !st_reg.loop_ctrl[0]
        |=> !o_pin[0])
        else $error("loop clock leaked");

    // Speaker disable then shutdown status next cycle
    spk_shut_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL13
        $fell(st_reg.spk_on) |=> st_reg.shut_done)
        else $error("shutdown status late");

    // Timer pulse sets its event
    timer_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL17
        raw_now[gpsco_pkg::EV_TIMER] && !st_reg.raw_prev[gpsco_pkg::EV_TIMER]
        |=> st_reg.events[gpsco_pkg::EV_TIMER])
        else $error("timer event lost");

    // Switch open while off
    switch_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL20
        st_reg.sw_mode == gpsco_pkg::SW_OFF |=> !o_switch_closed)
        else $error("switch closed while off");

    // Status sources routed to pin 0 one cycle later
    short_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL14
        st_reg.pin_fn[0] == gpsco_pkg::FN_SHORT
        |=> o_pin[0] == $past(raw_now[gpsco_pkg::EV_SHORT]))
        else $error("short status not on pin");

    timer_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL16
        st_reg.pin_fn[0] == gpsco_pkg::FN_TIMER_BASE
        |=> o_pin[0] == $past(raw_now[gpsco_pkg::EV_TIMER]))
        else $error("timer pulse not on pin");

    logger_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL18
        st_reg.pin_fn[0] == gpsco_pkg::FN_LOGGER_BASE
        |=> o_pin[0] == $past(raw_now[gpsco_pkg::EV_LOGGER]))
        else $error("logger flag not on pin");

    shut_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL13
        st_reg.pin_fn[0] == gpsco_pkg::FN_SHUTDOWN
        |=> o_pin[0] == $past(st_reg.shut_done))
        else $error("shutdown status not on pin");

    // Further sticky events
    logger_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL19
        raw_now[gpsco_pkg::EV_LOGGER] && !st_reg.raw_prev[gpsco_pkg::EV_LOGGER]
        |=> st_reg.events[gpsco_pkg::EV_LOGGER])
        else $error("logger event lost");

    warn_event_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL15
        raw_now[gpsco_pkg::EV_OVH_WARN] != st_reg.raw_prev[gpsco_pkg::EV_OVH_WARN]
        |=> st_reg.events[gpsco_pkg::EV_OVH_WARN])
        else $error("warning event lost");

    // Speaker protection latches; switch forced closed
    spk_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL13
        !st_reg.spk_on |=> !st_reg.spk_on)
        else $error("speaker enabled again");

    switch_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL20
        st_reg.sw_mode == gpsco_pkg::SW_ON |=> o_switch_closed)
        else $error("switch open while on");
endmodule

// File: tb/gpsco_partner.sv
// Far-side model: drives the status sources and the loop oscillator
`timescale 1ns/1ps
module gpsco_partner (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic [16:0] i_src,
    output logic             o_loop_osc,
    output logic             o_lock,
    output logic      [1:0]  o_pwm,
    output logic             o_spdif,
    output logic             o_spk_short,
    output logic             o_ovh_shut,
    output logic             o_ovh_warn,
    output logic             o_wdog,
    output logic      [3:0]  o_timer_done,
    output logic      [3:0]  o_logger_nempty,
    output logic             o_clamp
);
    logic [2:0] osc_cnt_reg;

    // Status levels follow the source vector the bench requests
    assign {o_clamp, o_logger_nempty, o_timer_done, o_wdog, o_ovh_warn, o_ovh_shut,
            o_spk_short, o_spdif, o_pwm, o_lock} = i_src;

    // Loop oscillator at a tenth of the core clock, well below clk/4
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_cnt_reg <= 3'h0;
            o_loop_osc  <= 1'b0;
        end else if (osc_cnt_reg == 3'h4) begin
            osc_cnt_reg <= 3'h0;
            o_loop_osc  <= ~o_loop_osc;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 3'h1;
        end
    end
endmodule

// File: tb/gpsco_top_bench.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module gpsco_top_bench;
    localparam logic [8:0] FN_TAB [16] = '{9'h018, 9'h048, 9'h049, 9'h04C, 9'h0B6, 9'h0E1,
        9'h0E2, 9'h000, 9'h140, 9'h141, 9'h142, 9'h143, 9'h150, 9'h151, 9'h152, 9'h153};
    localparam logic [2:0] SEL_TAB  [4] = '{3'h3, 3'h0, 3'h2, 3'h1};
    localparam int         DIV_TAB  [4] = '{2, 30, 4, 6};
    localparam logic [4:0] RATE_TAB [4] = '{5'h00, 5'h00, 5'h08, 5'h00};
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [4:0]  rate    = 5'h00;
    logic [16:0] src     = 17'h00000;
    logic [15:0] rdata;
    logic [3:0]  pin;
    logic        spk_en;
    logic        sw_closed;
    logic [12:0] events;
    logic        loop_osc, lock, spdif, spk_short, ovh_shut, ovh_warn, wdog, clamp;
    logic [1:0]  pwm;
    logic [3:0]  timer_done, logger_nempty;
    int          num_errors = 0;
    int          cmp_count  = 0;

    // Core clock, 100 MHz
    always #5 ref_clk = ~ref_clk;

    gpsco_top #(.NPINS(4)) i_gpsco_top (
        .i_ref_clk(ref_clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_loop_osc(loop_osc), .i_lock(lock), .i_pwm(pwm),
        .i_spdif(spdif), .i_spk_short(spk_short), .i_ovh_shut(ovh_shut),
        .i_ovh_warn(ovh_warn), .i_wdog(wdog), .i_timer_done(timer_done),
        .i_logger_nempty(logger_nempty), .i_mic_detect_clamp(clamp),
        .i_sample_rate(rate), .o_pin(pin), .o_spk_enable(spk_en),
        .o_switch_closed(sw_closed), .o_events(events));

    gpsco_partner i_gpsco_partner (
        .i_ref_clk(ref_clk), .i_rstn(rstn), .i_src(src), .o_loop_osc(loop_osc),
        .o_lock(lock), .o_pwm(pwm), .o_spdif(spdif), .o_spk_short(spk_short),
        .o_ovh_shut(ovh_shut), .o_ovh_warn(ovh_warn), .o_wdog(wdog),
        .o_timer_done(timer_done), .o_logger_nempty(logger_nempty), .o_clamp(clamp));

    // Bus access, waits and comparisons
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_src(input logic [16:0] v);
        @(posedge ref_clk);
        src <= v;
    endtask

    // Counts rising edges on pin 0 over n cycles
    task automatic measure(input int n, output int cnt);
        logic prev;
        cnt  = 0;
        #1;
        prev = pin[0];
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (pin[0] === 1'b1 && prev === 1'b0) cnt++;
            prev = pin[0];
        end
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well past the run of about 55,000 cycles
    initial begin
        #800_000;
        num_errors++;
        finish_test();
    end

    // Main test sequence
    initial begin
        int          cnt;
        int          freq;
        logic [15:0] ctrl;
        // Each protection cause shuts the speaker and shows shutdown on a pin
        for (int k = 0; k < 3; k++) begin
            do_reset();
            wait_cyc(1);
            chk({15'h0, spk_en}, 16'h0001);
            wr_reg(16'h0200, 16'h00E0);
            set_src(k == 0 ? 17'h00010 : (k == 1 ? 17'h00020 : 17'h00080));
            wait_cyc(8);
            chk({15'h0, spk_en}, 16'h0000);
            chk({15'h0, pin[0]}, 16'h0001);
            set_src(17'h0);
        end
        do_reset();
        rd_chk(gpsco_pkg::OFS_DCLK_CTRL, 16'h0000);
        rd_chk(gpsco_pkg::OFS_LOOP_CLK, 16'h000C);
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h0000);
        wr_reg(16'h0300, 16'hFFFF);
        rd_chk(16'h0300, 16'h0000);
        // Every status function code except shutdown 0x0E0 on a pin, high then low
        for (int b = 0; b < 16; b++) begin
            if (b != 7) begin
                wr_reg(16'h0200 + 16'(b % 4), {7'h00, FN_TAB[b]});
                set_src(17'h1 << b);
                wait_cyc(6);
                chk({15'h0, pin[b % 4]}, 16'h0001);
                set_src(17'h0);
                wait_cyc(6);
                chk({15'h0, pin[b % 4]}, 16'h0000);
            end
        end
        // Sticky events, write-one clear, both lock edges
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h1FFF);
        chk({3'h0, events}, 16'h1FFF);
        wr_reg(gpsco_pkg::OFS_EVENT, 16'h0001);
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h1FFE);
        set_src(17'h00001);
        wait_cyc(6);
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h1FFF);
        wr_reg(gpsco_pkg::OFS_EVENT, 16'h0001);
        set_src(17'h0);
        wait_cyc(6);
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h1FFF);
        wr_reg(gpsco_pkg::OFS_EVENT, 16'h1FFF);
        rd_chk(gpsco_pkg::OFS_EVENT, 16'h0000);
        chk({3'h0, events}, 16'h0000);
        rd_chk(gpsco_pkg::OFS_RAW, 16'h0004);
        // Loop clock gated, then divided by 6 and by 7
        wr_reg(16'h0200, {7'h00, gpsco_pkg::FN_LOOP_CLK});
        measure(600, cnt);
        chk_near(cnt, 0);
        wr_reg(gpsco_pkg::OFS_LOOP_CLK, 16'h000D);
        measure(6000, cnt);
        chk_near(cnt, 100);
        wr_reg(gpsco_pkg::OFS_LOOP_CLK, 16'h000C);
        wr_reg(gpsco_pkg::OFS_LOOP_CLK, 16'h000F);
        measure(6000, cnt);
        chk_near(cnt, 85);
        // Derived clock: configure disabled, then enable and count
        wr_reg(16'h0200, {7'h00, gpsco_pkg::FN_DCLK});
        for (int k = 0; k < 4; k++) begin
            ctrl = (16'(DIV_TAB[k]) << 3) | {13'h0, SEL_TAB[k]};
            @(posedge ref_clk);
            rate <= RATE_TAB[k];
            wr_reg(gpsco_pkg::OFS_DCLK_CTRL, ctrl);
            rd_chk(gpsco_pkg::OFS_DCLK_CTRL, ctrl);
            measure(300, cnt);
            chk_near(cnt, 0);
            wr_reg(gpsco_pkg::OFS_DCLK_CTRL, ctrl | 16'h8000);
            freq = (RATE_TAB[k][4:3] == 2'b01) ? gpsco_pkg::SRC_F_441[SEL_TAB[k]]
                                               : gpsco_pkg::SRC_F_48[SEL_TAB[k]];
            measure(10000, cnt);
            chk_near(cnt, freq / (DIV_TAB[k] * (gpsco_pkg::CORE_F / 10000)));
            wr_reg(gpsco_pkg::OFS_DCLK_CTRL, ctrl);
        end
        // Analog switch modes
        wr_reg(gpsco_pkg::OFS_SWITCH, 16'h0000);
        wait_cyc(6);
        chk({15'h0, sw_closed}, 16'h0000);
        wr_reg(gpsco_pkg::OFS_SWITCH, 16'h0001);
        wait_cyc(6);
        chk({15'h0, sw_closed}, 16'h0001);
        wr_reg(gpsco_pkg::OFS_SWITCH, 16'h0002);
        set_src(17'h10000);
        wait_cyc(6);
        chk({15'h0, sw_closed}, 16'h0001);
        set_src(17'h0);
        wait_cyc(6);
        chk({15'h0, sw_closed}, 16'h0000);
        finish_test();
    end
endmodule
